// ===== design/power_mode_clock_status.sv
// power mode tracking, clock event flags and power/reset control registers
// assumes apb master on the core side, oscillator events as 1-cycle pulses
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "power_mode_params.svh"
`default_nettype none
module power_mode_clock_status
   import power_mode_pkg::*;
(
   input wire logic clk, // system clock, 20 MHz
   input wire logic rst, // sync reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire cpu_events_t cpuEv, // core wait and cancel causes
   input wire osc_events_t oscEv, // oscillator event pulses
   input wire logic [4:0] resetCause, // reset request pulses, bit order as flags
   output op_mode_t opMode, // current operating mode
   output logic cpuClockRun, // cpu clock gate
   output logic modeCancel, // wake-up pulse
   output logic ramRetain, // ram kept powered
   output logic [3:0] sourceRun, // ext, high_speed_oscillator, low_speed_oscillator, internal_oscillator run enables
   output logic clgIrq, // clock generator interrupt
   output logic regDischargeEnable, // regulator discharge
   output logic regulatorVoltageSelect, // 1 mode0, 0 mode1
   output reg_op_mode_t regulatorOperatingMode, // decoded mode
   output logic resetPinPullupEnable, // pull-up on reset pin
   output logic resetPinInputEnable, // external reset accepted
   output logic [1:0] sysclkSource, // active clock source
   output logic [1:0] sysclkDivider // active divider
);
   logic [15:0] regCtl_reg, rstFlg_reg, pinCtl_reg, sclk_reg;
   logic [15:0] oscCtl_reg, intFlg_reg, intEn_reg, prot_reg;
   op_mode_t mode_reg, mode_next;
   logic [31:0] rdata_next;
   logic wrEn, unlocked, wakeEv, leaveSleep, badAddr;
   logic [15:0] wdata, intSet, intClr;
   logic [3:0] srcSel;

   // one-hot of a clock source code
   function automatic logic [3:0] src_onehot(input logic [1:0] code);
      src_onehot = 4'h1 << code;
   endfunction

   // masked write: bits under the mask take the new value, others keep the old
   function automatic logic [15:0] merge(input logic [15:0] old,
         input logic [15:0] nv, input logic [15:0] mask);
      merge = (old & ~mask) | (nv & mask);
   endfunction

   assign pready = 1'b1; // zero wait states keep the core simple
   assign wrEn = psel & penable & pwrite;
   assign wdata = pwdata[15:0];
   assign unlocked = (prot_reg == `PROT_KEY);
   assign wakeEv = cpuEv.periphIrq | cpuEv.wdtNmi | cpuEv.resetReq;

   // unmapped offsets answer with an error
   always_comb begin
      badAddr = 1'b1;
      if (paddr == `OFF_REGCTL) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_RSTFLG) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_PINCTL) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_SCLK) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_PROT) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_OSCCTL) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_INTFLG) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_INTEN) begin
         badAddr = 1'b0;
      end else if (paddr == `OFF_STATUS) begin
         badAddr = 1'b0;
      end
   end
   assign pslverr = psel & penable & badAddr;

   // mode machine: wait enters halt or sleep, any cancel cause wakes
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN: begin
            if (cpuEv.waitExec && !wakeEv) begin
               if (cpuEv.deepSleepSelect) begin
                  mode_next = MODE_SLEEP;
               end else begin
                  mode_next = MODE_HALT;
               end
            end
         end
         MODE_HALT: begin
            if (wakeEv) begin
               mode_next = MODE_RUN;
            end
         end
         MODE_SLEEP: begin
            if (wakeEv) begin
               mode_next = MODE_RUN;
            end
         end
         default: begin
            mode_next = MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= MODE_RUN;
      end else begin
         mode_reg <= mode_next;
      end
   end
   assign leaveSleep = (mode_reg == MODE_SLEEP) && (mode_next == MODE_RUN);

   // mode outputs are registered for glitch-free clock gating
   always_ff @(posedge clk) begin
      if (rst) begin
         opMode <= MODE_RUN;
         cpuClockRun <= 1'b1;
         modeCancel <= 1'b0;
      end else begin
         opMode <= mode_next;
         cpuClockRun <= (mode_next == MODE_RUN);
         modeCancel <= (mode_reg != MODE_RUN) && wakeEv;
      end
   end

   // ram stays powered in every mode, sleep included
   assign ramRetain = 1'b1;

   // source runs if enabled or selected; sleep stops only marked ones
   always_comb begin
      srcSel = oscCtl_reg[3:0] | src_onehot(sclk_reg[1:0]);
      if (mode_reg == MODE_SLEEP) begin
         srcSel = srcSel & ~oscCtl_reg[11:8];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         sourceRun <= 4'h1;
      end else begin
         sourceRun <= srcSel;
      end
   end

   // event flag sources; stop flag also on enable falling edges
   always_comb begin
      intSet = 16'h0000;
      intSet[0] = oscEv.internalOscStable;
      intSet[1] = oscEv.lowSpeedOscStable;
      intSet[2] = oscEv.highSpeedOscStable;
      intSet[3] = oscEv.lowSpeedOscStopped;
      intSet[4] = oscEv.trimDone;
      intSet[5] = oscEv.trimError;
      if (wrEn && paddr == `OFF_OSCCTL && oscCtl_reg[`OSC_LSEN_BIT]
            && !wdata[`OSC_LSEN_BIT]) begin
         intSet[3] = 1'b1;
      end
      if (wrEn && unlocked && paddr == `OFF_OSCCTL && oscCtl_reg[12]
            && !wdata[12]) begin
         intSet[3] = 1'b1;
      end
      intClr = 16'h0000;
      if (wrEn && paddr == `OFF_INTFLG) begin
         intClr = wdata & `INT_MASK;
      end
   end

   // sticky flags: set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         intFlg_reg <= 16'h0000;
      end else begin
         intFlg_reg <= (intFlg_reg & ~intClr) | intSet;
      end
   end
   assign clgIrq = |(intFlg_reg & intEn_reg);

   // reset cause flags, write one clears, new cause wins
   always_ff @(posedge clk) begin
      if (rst) begin
         rstFlg_reg <= `RSTFLG_RST;
      end else begin
         rstFlg_reg <= ((rstFlg_reg & ~((wrEn && paddr == `OFF_RSTFLG)
            ? (wdata & `RSTFLG_MASK) : 16'h0000))
            | {11'h000, resetCause}) & `RSTFLG_MASK;
      end
   end

   // protection key register
   always_ff @(posedge clk) begin
      if (rst) begin
         prot_reg <= 16'h0000;
      end else if (wrEn && paddr == `OFF_PROT) begin
         prot_reg <= wdata;
      end
   end

   // protected control registers; reserved bits kept at zero
   always_ff @(posedge clk) begin
      if (rst) begin
         regCtl_reg <= `REGCTL_RST;
         pinCtl_reg <= `PINCTL_RST;
      end else if (wrEn && unlocked) begin
         if (paddr == `OFF_REGCTL) begin
            regCtl_reg <= wdata & `REGCTL_MASK;
         end else if (paddr == `OFF_PINCTL) begin
            pinCtl_reg <= wdata & `PINCTL_MASK;
         end
      end
   end

   // clock select; wake-up switch loads active fields on leaving sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_reg <= `SCLK_RST;
      end else if (leaveSleep && sclk_reg[`SCLK_WUPEN_BIT]) begin
         sclk_reg <= {sclk_reg[15:8], 2'b00, sclk_reg[13:12], 2'b00,
            sclk_reg[9:8]};
      end else if (wrEn && unlocked && paddr == `OFF_SCLK) begin
         sclk_reg <= wdata & `SCLK_MASK;
      end
   end

   // oscillator control (bit 12 holds stop detector enable); enables
   always_ff @(posedge clk) begin
      if (rst) begin
         oscCtl_reg <= `OSCCTL_RST;
         intEn_reg <= 16'h0000;
      end else if (wrEn) begin
         if (paddr == `OFF_OSCCTL) begin
            oscCtl_reg <= (wdata & `OSCCTL_MASK)
               | ((unlocked ? wdata : oscCtl_reg) & 16'h1000);
         end else if (paddr == `OFF_INTEN) begin
            intEn_reg <= wdata & `INT_MASK;
         end
      end
   end

   // read mux, registered so data comes from flops one cycle after setup
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (paddr == `OFF_REGCTL) begin
         rdata_next = {16'h0000, regCtl_reg};
      end else if (paddr == `OFF_RSTFLG) begin
         rdata_next = {16'h0000, rstFlg_reg};
      end else if (paddr == `OFF_PINCTL) begin
         rdata_next = {16'h0000, pinCtl_reg};
      end else if (paddr == `OFF_SCLK) begin
         rdata_next = {16'h0000, sclk_reg};
      end else if (paddr == `OFF_PROT) begin
         rdata_next = {31'h0000_0000, unlocked};
      end else if (paddr == `OFF_OSCCTL) begin
         rdata_next = {16'h0000, oscCtl_reg};
      end else if (paddr == `OFF_INTFLG) begin
         rdata_next = {16'h0000, intFlg_reg};
      end else if (paddr == `OFF_INTEN) begin
         rdata_next = {16'h0000, intEn_reg};
      end else if (paddr == `OFF_STATUS) begin
         rdata_next = {26'h000_0000, sourceRun, mode_reg};
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rdata_next;
      end
   end

   // register fields to pins
   assign regDischargeEnable = regCtl_reg[5];
   assign regulatorVoltageSelect = regCtl_reg[4];
   assign regulatorOperatingMode = reg_op_mode_t'(regCtl_reg[1:0]);
   assign resetPinPullupEnable = pinCtl_reg[1];
   assign resetPinInputEnable = pinCtl_reg[0];
   assign sysclkSource = sclk_reg[1:0];
   assign sysclkDivider = sclk_reg[5:4];

   // checks
   sleep_entry_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg == MODE_RUN && cpuEv.waitExec && cpuEv.deepSleepSelect
      && !wakeEv) |=> mode_reg == MODE_SLEEP)
      else $error("sleep not entered");
   halt_entry_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg == MODE_RUN && cpuEv.waitExec && !cpuEv.deepSleepSelect
      && !wakeEv) |=> mode_reg == MODE_HALT ##1 cpuClockRun == 1'b0)
      else $error("halt not entered");
   wake_cancel_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg != MODE_RUN && wakeEv) |=> modeCancel
      && mode_reg == MODE_RUN)
      else $error("wake did not cancel");
   flag_set_a: assert property (@(posedge clk) disable iff (rst)
      oscEv.trimDone |=> intFlg_reg[4])
      else $error("trim flag lost");
   irq_gate_a: assert property (@(posedge clk) disable iff (rst)
      clgIrq == |(intFlg_reg & intEn_reg & `INT_MASK))
      else $error("irq gating wrong");
   sleep_keep_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg == MODE_SLEEP && !oscCtl_reg[8] && oscCtl_reg[0])
      |=> sourceRun[0])
      else $error("source stopped in sleep");
   protect_a: assert property (@(posedge clk) disable iff (rst)
      (!unlocked && !leaveSleep) |=> $stable(sclk_reg))
      else $error("protected write passed");
   wake_copy_a: assert property (@(posedge clk) disable iff (rst)
      (leaveSleep && sclk_reg[15]) |=> sclk_reg[1:0] == $past(sclk_reg[9:8])
      && sclk_reg[5:4] == $past(sclk_reg[13:12]))
      else $error("wake-up copy wrong");
   rst_flag_a: assert property (@(posedge clk) disable iff (rst)
      resetCause[2] |=> rstFlg_reg[2])
      else $error("reset flag lost");
endmodule
`default_nettype wire

// ===== design/power_mode_params.svh
// constants for the power mode / clock status block: offsets, fields, resets
// assumes an APB slave with 32-bit data, one aligned word per register
// Contract
// - run mode after system reset release
// - wait with deep select 0 enters halt
// - wait with deep select 1 enters sleep
// - sources with sleep-stop 0 keep running
// - ram contents kept during sleep
// - interrupt, watchdog nmi or reset cancel wait
// - per-source stable flags, write one clears
// - low_speed_oscillator stop flag on stop or enable fall
// - trim done and trim error flags
// - interrupt only when flag and enable set
// - bit 5 discharge enable, reset 0
// - bit 4 voltage select, reset 1
// - operating mode codes 3,2,0; 1 reserved
// - reset flags read 1, write one clears
// - reset flags at bits 4..0, resets 1,1,0,0,0
// - pin bit 1 pull-up enable, reset 1
// - pin bit 0 reset input enable, reset 1
// - clock register fields, reset zero
// - wake-up switch copies fields leaving sleep
// - source codes; selecting stopped source starts it
// - key 0x0096 unlocks protected bits
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH
`define OFF_REGCTL 12'h000
`define OFF_RSTFLG 12'h004
`define OFF_PINCTL 12'h008
`define OFF_SCLK 12'h00C
`define OFF_PROT 12'h010
`define OFF_OSCCTL 12'h014
`define OFF_INTFLG 12'h018
`define OFF_INTEN 12'h01C
`define OFF_STATUS 12'h020
`define REGCTL_MASK 16'h0033
`define REGCTL_RST 16'h0010
`define RSTFLG_MASK 16'h001F
`define RSTFLG_RST 16'h0018
`define PINCTL_MASK 16'h0003
`define PINCTL_RST 16'h0003
`define SCLK_MASK 16'hB333
`define SCLK_RST 16'h0000
`define OSCCTL_MASK 16'h0F0F
`define OSCCTL_RST 16'h0F01
`define INT_MASK 16'h003F
`define PROT_KEY 16'h0096
`define SCLK_WUPEN_BIT 15
`define OSC_LSEN_BIT 1
`endif

// ===== design/power_mode_pkg.sv
// types shared by the power mode block
// assumes the params header is included alongside
`default_nettype none
package power_mode_pkg;
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_HALT = 2'b01,
      MODE_SLEEP = 2'b10
   } op_mode_t;
   typedef enum logic [1:0] {
      REGM_AUTO = 2'b00,
      REGM_RSVD = 2'b01,
      REGM_NORMAL = 2'b10,
      REGM_ECONOMY = 2'b11
   } reg_op_mode_t;
   typedef struct packed {
      logic waitExec;
      logic deepSleepSelect;
      logic periphIrq;
      logic wdtNmi;
      logic resetReq;
   } cpu_events_t;
   typedef struct packed {
      logic internalOscStable;
      logic lowSpeedOscStable;
      logic highSpeedOscStable;
      logic lowSpeedOscStopped;
      logic trimDone;
      logic trimError;
   } osc_events_t;
endpackage
`default_nettype wire

// ===== verification/core_model.sv
// core-side model: apb master plus wait-instruction and wake-cause driver
// assumes the slave may stretch the access phase through pready
`include "power_mode_params.svh"
`default_nettype none
module core_model
   import power_mode_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic [31:0] prdata, // apb read data
   output var logic psel, // apb select
   output var logic penable, // apb enable
   output var logic pwrite, // apb direction
   output var logic [11:0] paddr, // apb address
   output var logic [31:0] pwdata, // apb write data
   output var cpu_events_t cpuEv // wait and wake causes
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus and core idle from time zero
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      cpuEv = '0;
   end
   // one transfer, request held until pready is seen high at an edge, for at most 50 edges
   task automatic xfer(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // software writes the key before touching protected bits
   task automatic unlock(input logic on);
      logic [31:0] q;
      logic e;
      xfer(1'b1, `OFF_PROT, on ? 32'h0000_0096 : 32'h0000_0000, q, e);
   endtask
   // one wait instruction; deep picks sleep over halt
   task automatic waitInstr(input logic deep);
      @(posedge clk);
      cpuEv.waitExec <= 1'b1;
      cpuEv.deepSleepSelect <= deep;
      @(posedge clk);
      cpuEv.waitExec <= 1'b0;
   endtask
   // wake cause for one cycle: 0 irq, 1 watchdog nmi, 2 reset request
   task automatic wake(input int k);
      @(posedge clk);
      cpuEv[2-k] <= 1'b1;
      @(posedge clk);
      cpuEv[2-k] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verification/power_mode_clock_status_tb_top.sv
// self-checking bench for the power mode / clock status block
// assumes core_model as the apb master and wait-instruction source
`include "power_mode_params.svh"
`default_nettype none
module power_mode_clock_status_tb_top
   import power_mode_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   cpu_events_t cpuEv;
   osc_events_t oscEv;
   logic [4:0] resetCause;
   op_mode_t opMode;
   logic cpuClockRun, modeCancel, ramRetain, clgIrq;
   logic [3:0] sourceRun;
   logic regDischargeEnable, regulatorVoltageSelect;
   reg_op_mode_t regulatorOperatingMode;
   logic resetPinPullupEnable, resetPinInputEnable;
   logic [1:0] sysclkSource, sysclkDivider;
   int failures = 0;
   int num_checks = 0;

   power_mode_clock_status u_power_mode_clock_status (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpuEv(cpuEv), .oscEv(oscEv), .resetCause(resetCause),
      .opMode(opMode), .cpuClockRun(cpuClockRun), .modeCancel(modeCancel),
      .ramRetain(ramRetain), .sourceRun(sourceRun), .clgIrq(clgIrq),
      .regDischargeEnable(regDischargeEnable),
      .regulatorVoltageSelect(regulatorVoltageSelect),
      .regulatorOperatingMode(regulatorOperatingMode),
      .resetPinPullupEnable(resetPinPullupEnable),
      .resetPinInputEnable(resetPinInputEnable),
      .sysclkSource(sysclkSource), .sysclkDivider(sysclkDivider));
   core_model u_core_model (.clk(clk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .cpuEv(cpuEv));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // verdict and end of run, shared by the main sequence and the watchdog
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      u_core_model.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      u_core_model.xfer(1'b0, a, 32'h0000_0000, q, e);
      chk(q, exp);
   endtask
   // reset values and an unmapped read
   task automatic t_reset();
      logic [31:0] q;
      logic e;
      chk(32'(opMode), 32'(MODE_RUN));
      chk(32'(cpuClockRun), 32'h0000_0001);
      rd(`OFF_REGCTL, 32'h0000_0010);
      rd(`OFF_RSTFLG, 32'h0000_0018);
      rd(`OFF_PINCTL, 32'h0000_0003);
      rd(`OFF_SCLK, 32'h0000_0000);
      u_core_model.xfer(1'b0, 12'h040, 32'h0000_0000, q, e);
      chk(q, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
   endtask
   // protection, every operating-mode code, reserved bits
   task automatic t_regctl();
      wr(`OFF_REGCTL, 32'h0000_0033);
      rd(`OFF_REGCTL, 32'h0000_0010);
      u_core_model.unlock(1'b1);
      for (int c = 0; c < 4; c++) begin
         wr(`OFF_REGCTL, 32'h0000_0020 | c);
         rd(`OFF_REGCTL, 32'h0000_0020 | c);
         chk(32'(regulatorOperatingMode), c);
         chk(32'(regDischargeEnable), 32'h0000_0001);
         chk(32'(regulatorVoltageSelect), 32'h0000_0000);
      end
      wr(`OFF_REGCTL, 32'hFFFF_FFFF);
      rd(`OFF_REGCTL, 32'h0000_0033);
   endtask
   // reset flags: write zero ineffective, write one clears, pulses set
   task automatic t_rstflg();
      wr(`OFF_RSTFLG, 32'h0000_0000);
      rd(`OFF_RSTFLG, 32'h0000_0018);
      wr(`OFF_RSTFLG, 32'h0000_0008);
      rd(`OFF_RSTFLG, 32'h0000_0010);
      @(posedge clk);
      resetCause <= 5'h07;
      @(posedge clk);
      resetCause <= 5'h00;
      rd(`OFF_RSTFLG, 32'h0000_0017);
      wr(`OFF_RSTFLG, 32'h0000_001F);
      rd(`OFF_RSTFLG, 32'h0000_0000);
   endtask
   // reset pin pull-up and input enable
   task automatic t_pin();
      wr(`OFF_PINCTL, 32'h0000_0001);
      rd(`OFF_PINCTL, 32'h0000_0001);
      chk(32'(resetPinPullupEnable), 32'h0000_0000);
      chk(32'(resetPinInputEnable), 32'h0000_0001);
   endtask
   // each event flag: sticky, masked interrupt, write-one clear
   task automatic t_flags();
      for (int i = 0; i < 6; i++) begin
         wr(`OFF_INTEN, 32'h0000_0001 << i);
         @(posedge clk);
         oscEv <= osc_events_t'(6'b00_0001 << (5 - i));
         @(posedge clk);
         oscEv <= '0;
         rd(`OFF_INTFLG, 32'h0000_0001 << i);
         chk(32'(clgIrq), 32'h0000_0001);
         wr(`OFF_INTEN, 32'h0000_0000);
         // the enable lands at the edge wr returns on; let it settle first
         #1 chk(32'(clgIrq), 32'h0000_0000);
         wr(`OFF_INTFLG, 32'h0000_0001 << i);
         rd(`OFF_INTFLG, 32'h0000_0000);
      end
      wr(`OFF_OSCCTL, 32'h0000_0F03);
      wr(`OFF_OSCCTL, 32'h0000_0F01);
      rd(`OFF_INTFLG, 32'h0000_0008);
      wr(`OFF_INTFLG, 32'h0000_0008);
   endtask
   // halt with every wake cause, then sleep with wake-up clock switch
   task automatic t_modes();
      for (int k = 0; k < 3; k++) begin
         u_core_model.waitInstr(1'b0);
         repeat (3) @(posedge clk);
         #1 chk(32'(opMode), 32'(MODE_HALT));
         chk(32'(cpuClockRun), 32'h0000_0000);
         u_core_model.wake(k);
         #1 chk(32'(modeCancel), 32'h0000_0001);
         @(posedge clk);
         #1 chk(32'(modeCancel), 32'h0000_0000);
         chk(32'(opMode), 32'(MODE_RUN));
      end
      u_core_model.unlock(1'b1);
      wr(`OFF_OSCCTL, 32'h0000_0E01);
      wr(`OFF_SCLK, 32'h0000_9201);
      repeat (3) @(posedge clk);
      #1 chk(32'(sourceRun[1]), 32'h0000_0001);
      u_core_model.waitInstr(1'b1);
      repeat (3) @(posedge clk);
      #1 chk(32'(opMode), 32'(MODE_SLEEP));
      chk(32'(sourceRun), 32'h0000_0001);
      chk(32'(ramRetain), 32'h0000_0001);
      u_core_model.wake(0);
      repeat (3) @(posedge clk);
      #1 chk(32'(sysclkSource), 32'h0000_0002);
      chk(32'(sysclkDivider), 32'h0000_0001);
      chk(32'(sourceRun[2]), 32'h0000_0001);
   endtask
   // watchdog against a hung handshake
   initial begin
      #(50 * 20000);
      failures++;
      print_verdict();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      oscEv = '0;
      resetCause = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_regctl();
      t_rstflg();
      t_pin();
      t_flags();
      t_modes();
      print_verdict();
   end
endmodule
`default_nettype wire
